/* File: rtl/gid_decoder.sv */
// Behaviour
// RQ1: software mode field picks the decoding scheme
// RQ2: register-enable mode: high input picks gate
// RQ3: register-enable mode ignores low input pins
// RQ4: drive enable clear forces phase gates low
// RQ5: phase-A high pin is the shared PWM
// RQ6: three state pins index six-step table
// RQ7: controller or Hall sensors drive state pins
// RQ8: direction input complements the state code; the code leaves the stop (000) and align (111) codes uncomplemented
// RQ9: brake low: all high off, lows on
// RQ10: eight state codes decode to table rows
// RQ11: source high follows PWM, sink low on
// RQ12: recirculation 0: source low is inverse PWM
// RQ13: recirculation 1: source low held off
// RQ14: software gate bits, conflict forces low
// RQ15: pins synchronised; reset, bad mode: gates low
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module gid_decoder #(
  parameter int ADDR_W = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // controller pins
  input wire gid_pkg::gid_pins_s phase_input,
  // gate outputs
  output gid_pkg::gid_gate_s gate_out
);
  import gid_pkg::*;

  if (ADDR_W < 4) begin : g_bad_addr_w
    $error("gid_decoder: ADDR_W must be at least 4");
  end

  typedef struct packed {
    gid_pins_s s1;
    gid_pins_s s2;
    gid_pins_s s3;
    gid_pins_s filt;
    gid_pins_s in_d;
    logic [2:0] mode;
    logic recirc;
    logic [2:0] drv_en;
    logic [2:0] sw_low;
    logic [2:0] sw_high;
    gid_gate_s gate;
    logic [31:0] rdata;
  } gid_state_s;

  gid_state_s st_r;
  gid_state_s st_nxt;

  logic [2:0] state_code;
  logic direction_input;
  logic [2:0] rom_addr;
  gid_roles_t roles;
  logic single_pwm_input;
  logic brake_input_n;
  logic setup_phase;
  logic access_phase;
  logic hit_ctrl;
  logic hit_cmd;
  logic hit_stat;

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
    addr_is = (a == ADDR_W'(ofs));
  endfunction : addr_is

  // commutation inputs, taken from the filtered pins
  // RQ6 state pins code
  assign state_code = {st_r.filt.low[0], st_r.filt.high[1], st_r.filt.low[1]};
  assign direction_input = st_r.filt.high[2];
  // RQ8 reverse direction code
  assign rom_addr = (direction_input && state_code != GID_CODE_STOP && state_code != GID_CODE_ALIGN)
                    ? ~state_code : state_code;

  gid_step_rom u_rom (
    .pclk(pclk),
    .presetn(presetn),
    .addr(rom_addr),
    .roles(roles)
  );

  // RQ5 pwm from phase A
  assign single_pwm_input = st_r.in_d.high[0];
  assign brake_input_n = st_r.in_d.low[2];

  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign hit_ctrl = addr_is(paddr, GID_OFS_CTRL);
  assign hit_cmd = addr_is(paddr, GID_OFS_GATE_CMD);
  assign hit_stat = addr_is(paddr, GID_OFS_STATUS);

  always_comb begin
    st_nxt = st_r;
    // RQ15 three-stage pin synchroniser
    st_nxt.s1 = phase_input;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.filt = st_r.s3;
    end
    st_nxt.in_d = st_r.filt;

    // register writes at the access edge
    if (access_phase && pwrite && hit_ctrl) begin
      st_nxt.mode = pwdata[GID_CTRL_MODE_LSB +: 3];
      st_nxt.recirc = pwdata[GID_CTRL_RECIRC_BIT];
      st_nxt.drv_en = pwdata[GID_CTRL_EN_LSB +: 3];
    end
    if (access_phase && pwrite && hit_cmd) begin
      st_nxt.sw_low = pwdata[GID_CMD_LOW_LSB +: 3];
      st_nxt.sw_high = pwdata[GID_CMD_HIGH_LSB +: 3];
    end
    // read data captured in the setup cycle
    if (setup_phase) begin
      st_nxt.rdata = '0;
      if (hit_ctrl) begin
        st_nxt.rdata[GID_CTRL_MODE_LSB +: 3] = st_r.mode;
        st_nxt.rdata[GID_CTRL_RECIRC_BIT] = st_r.recirc;
        st_nxt.rdata[GID_CTRL_EN_LSB +: 3] = st_r.drv_en;
      end else if (hit_cmd) begin
        st_nxt.rdata[GID_CMD_LOW_LSB +: 3] = st_r.sw_low;
        st_nxt.rdata[GID_CMD_HIGH_LSB +: 3] = st_r.sw_high;
      end else if (hit_stat) begin
        st_nxt.rdata[GID_STAT_HIGH_LSB +: 3] = st_r.gate.high;
        st_nxt.rdata[GID_STAT_LOW_LSB +: 3] = st_r.gate.low;
        st_nxt.rdata[GID_STAT_CODE_LSB +: 3] = rom_addr;
      end
    end

    // gate decode
    st_nxt.gate = '0;
    // RQ1 mode select
    case (st_r.mode)
      GID_MODE_SIX: begin
        st_nxt.gate.high = st_r.in_d.high & ~st_r.in_d.low;
        st_nxt.gate.low = st_r.in_d.low & ~st_r.in_d.high;
      end
      GID_MODE_THREE_PIN: begin
        st_nxt.gate.high = st_r.in_d.low & st_r.in_d.high;
        st_nxt.gate.low = st_r.in_d.low & ~st_r.in_d.high;
      end
      GID_MODE_THREE_REG: begin
        // RQ2 high input picks gate
        // RQ3 low pins unused
        st_nxt.gate.high = st_r.in_d.high;
        st_nxt.gate.low = ~st_r.in_d.high;
      end
      GID_MODE_SINGLE: begin
        for (int i = 0; i < GID_NPH; i++) begin
          case (roles[2*i +: 2])
            GID_ROLE_SRC: begin
              // RQ11 source follows pwm
              st_nxt.gate.high[i] = single_pwm_input;
              // RQ12 synchronous recirculation
              // RQ13 asynchronous recirculation
              st_nxt.gate.low[i] = st_r.recirc ? 1'b0 : ~single_pwm_input;
            end
            GID_ROLE_SINK: begin
              // RQ11 sink low held on
              st_nxt.gate.low[i] = 1'b1;
            end
            default: begin
              st_nxt.gate.high[i] = 1'b0;
              st_nxt.gate.low[i] = 1'b0;
            end
          endcase
        end
        // RQ9 brake overrides all
        if (!brake_input_n) begin
          st_nxt.gate.high = 3'h0;
          st_nxt.gate.low = 3'h7;
        end
      end
      GID_MODE_SWREG: begin
        // RQ14 software gate bits
        st_nxt.gate.high = st_r.sw_high & ~st_r.sw_low;
        st_nxt.gate.low = st_r.sw_low & ~st_r.sw_high;
      end
      default: begin
        // RQ15 undefined mode low
        st_nxt.gate = '0;
      end
    endcase
    // RQ4 per-phase enable
    st_nxt.gate.high = st_nxt.gate.high & st_r.drv_en;
    st_nxt.gate.low = st_nxt.gate.low & st_r.drv_en;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.mode <= GID_RST_MODE;
      st_r.recirc <= GID_RST_RECIRC;
      st_r.drv_en <= GID_RST_EN;
      st_r.sw_low <= GID_RST_CMD;
      st_r.sw_high <= GID_RST_CMD;
    end else begin
      st_r <= st_nxt;
    end
  end

  // zero-wait slave
  assign pready = 1'b1;
  assign pslverr = access_phase && !(hit_ctrl || hit_cmd || hit_stat);
  assign prdata = st_r.rdata;
  // RQ15 gates from flops, low in reset
  assign gate_out = st_r.gate;

  // checks
  a_enable_forces_low: // RQ4
  assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> ((gate_out.high | gate_out.low) & ~$past(st_r.drv_en)) == 3'h0)
  else $error("gate on while drive enable cleared");

  a_reg_enable_high: // RQ2
  assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.mode == GID_MODE_THREE_REG && st_r.drv_en == 3'h7)
    |=> gate_out.high == $past(st_r.in_d.high) && gate_out.low == ~$past(st_r.in_d.high))
  else $error("register-enable mode gate mismatch");

  a_low_pins_ignored: // RQ3
  assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.mode == GID_MODE_THREE_REG && $stable(st_r.mode) && $stable(st_r.drv_en)
     && $stable(st_r.in_d.high)) |=> $stable(gate_out))
  else $error("low pins changed gates in register-enable mode");

  a_dir_complement: // RQ8
  assert property (@(posedge pclk) disable iff (!presetn)
    (direction_input && state_code == 3'b001)
    |=> roles == {GID_ROLE_SINK, GID_ROLE_SRC, GID_ROLE_IDLE})
  else $error("direction did not complement state code");

  a_table_rows: // RQ10
  assert property (@(posedge pclk) disable iff (!presetn)
    (rom_addr == 3'b100) |=> roles == {GID_ROLE_SINK, GID_ROLE_IDLE, GID_ROLE_SRC})
  else $error("row A to C wrong");

  a_stop_row_idle: // RQ10
  assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.mode == GID_MODE_SINGLE && brake_input_n && $past(rom_addr) == GID_CODE_STOP)
    |=> gate_out.high == 3'h0 && gate_out.low == 3'h0)
  else $error("stop code drove a gate");

  a_brake_override: // RQ9
  assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.mode == GID_MODE_SINGLE && !brake_input_n)
    |=> gate_out.high == 3'h0 && gate_out.low == $past(st_r.drv_en))
  else $error("brake did not override");

  a_sync_recirc: // RQ12
  assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.mode == GID_MODE_SINGLE && brake_input_n && !st_r.recirc
     && st_r.drv_en[0] && roles[1:0] == GID_ROLE_SRC)
    |=> gate_out.high[0] == $past(single_pwm_input) && gate_out.low[0] == !$past(single_pwm_input))
  else $error("synchronous source phase wrong");

  a_async_recirc: // RQ13
  assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.mode == GID_MODE_SINGLE && brake_input_n && st_r.recirc && roles[3:2] == GID_ROLE_SRC)
    |=> !gate_out.low[1])
  else $error("asynchronous source low gate on");

  a_sw_gate_bits: // RQ14
  assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.mode == GID_MODE_SWREG)
    |=> gate_out.high == ($past(st_r.sw_high) & ~$past(st_r.sw_low) & $past(st_r.drv_en))
        && gate_out.low == ($past(st_r.sw_low) & ~$past(st_r.sw_high) & $past(st_r.drv_en)))
  else $error("software gate bits mismatch");

  a_bad_mode_low: // RQ15
  assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.mode > GID_MODE_SWREG) |=> gate_out == '0)
  else $error("undefined mode drove a gate");

  a_sync_latency: // RQ15
  assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.s2 == st_r.s3) |=> st_r.filt == $past(st_r.s3))
  else $error("filtered pins did not follow agreed stages");
endmodule : gid_decoder
`default_nettype wire

/* File: include/gid_pkg.sv */
`default_nettype none
package gid_pkg;
  // phase count and register word layout
  localparam int GID_NPH = 3;
  localparam int GID_DW = 32;
  localparam logic [3:0] GID_OFS_CTRL = 4'h0;
  localparam logic [3:0] GID_OFS_GATE_CMD = 4'h4;
  localparam logic [3:0] GID_OFS_STATUS = 4'h8;

  // input decoding modes
  localparam logic [2:0] GID_MODE_SIX = 3'h0;
  localparam logic [2:0] GID_MODE_THREE_PIN = 3'h1;
  localparam logic [2:0] GID_MODE_THREE_REG = 3'h2;
  localparam logic [2:0] GID_MODE_SINGLE = 3'h3;
  localparam logic [2:0] GID_MODE_SWREG = 3'h4;

  // per-phase role in a commutation row
  localparam logic [1:0] GID_ROLE_IDLE = 2'h0;
  localparam logic [1:0] GID_ROLE_SINK = 2'h1;
  localparam logic [1:0] GID_ROLE_SRC = 2'h2;

  // commutation codes with special meaning
  localparam logic [2:0] GID_CODE_STOP = 3'h0;
  localparam logic [2:0] GID_CODE_ALIGN = 3'h7;

  // field positions
  localparam int GID_CTRL_MODE_LSB = 0;
  localparam int GID_CTRL_RECIRC_BIT = 3;
  localparam int GID_CTRL_EN_LSB = 4;
  localparam int GID_CMD_LOW_LSB = 0;
  localparam int GID_CMD_HIGH_LSB = 4;
  localparam int GID_STAT_HIGH_LSB = 0;
  localparam int GID_STAT_LOW_LSB = 4;
  localparam int GID_STAT_CODE_LSB = 8;

  // reset values
  localparam logic [2:0] GID_RST_MODE = 3'h0;
  localparam logic GID_RST_RECIRC = 1'b0;
  localparam logic [2:0] GID_RST_EN = 3'h7;
  localparam logic [2:0] GID_RST_CMD = 3'h0;

  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } gid_pins_s;

  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } gid_gate_s;

  // roles of phases C, B, A from msb down
  typedef logic [5:0] gid_roles_t;
endpackage : gid_pkg
`default_nettype wire

/* File: rtl/gid_step_rom.sv */
`timescale 1ns/1ns
`default_nettype none
module gid_step_rom (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // lookup
  input wire logic [2:0] addr,
  output gid_pkg::gid_roles_t roles
);
  import gid_pkg::*;

  typedef struct packed {
    gid_roles_t roles;
  } gid_rom_state_s;

  gid_rom_state_s st_r;
  gid_rom_state_s st_nxt;

  function automatic gid_roles_t row(input logic [2:0] code);
    // RQ10 six-step table rows
    case (code)
      3'b111: row = {GID_ROLE_SINK, GID_ROLE_SINK, GID_ROLE_SRC};
      3'b110: row = {GID_ROLE_SINK, GID_ROLE_SRC, GID_ROLE_IDLE};
      3'b100: row = {GID_ROLE_SINK, GID_ROLE_IDLE, GID_ROLE_SRC};
      3'b101: row = {GID_ROLE_IDLE, GID_ROLE_SINK, GID_ROLE_SRC};
      3'b001: row = {GID_ROLE_SRC, GID_ROLE_SINK, GID_ROLE_IDLE};
      3'b011: row = {GID_ROLE_SRC, GID_ROLE_IDLE, GID_ROLE_SINK};
      3'b010: row = {GID_ROLE_IDLE, GID_ROLE_SRC, GID_ROLE_SINK};
      default: row = {GID_ROLE_IDLE, GID_ROLE_IDLE, GID_ROLE_IDLE};
    endcase
  endfunction : row

  always_comb begin
    st_nxt = st_r;
    st_nxt.roles = row(addr);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign roles = st_r.roles;
endmodule : gid_step_rom
`default_nettype wire

/* File: testbench/gid_ctl_model.sv */
`timescale 1ns/1ns
`default_nettype none
module gid_ctl_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // commands from the bench
  input wire logic single,
  input wire logic pwm,
  input wire logic [2:0] code,
  input wire logic dir,
  input wire logic brake_n,
  input wire gid_pkg::gid_pins_s raw,
  // controller pins
  output gid_pkg::gid_pins_s pins
);
  import gid_pkg::*;
  gid_pins_s pins_r;
  assign pins = pins_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_r <= '0;
    end else if (single) begin
      pins_r <= '{high: {dir, code[1], pwm}, low: {brake_n, code[0], code[2]}};
    end else begin
      pins_r <= raw;
    end
  end
endmodule : gid_ctl_model
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import gid_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [3:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  gid_pins_s pins, raw;
  gid_gate_s gate_out;
  logic single, pwm, dir, brake_n, rc_v;
  logic [2:0] code, mode_v, en_v;
  logic [5:0] cmd_v;
  int n_mismatch, samples_checked;

  gid_decoder u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_input(pins), .gate_out(gate_out));
  gid_ctl_model u_ctl (.pclk(pclk), .presetn(presetn), .single(single), .pwm(pwm), .code(code),
    .dir(dir), .brake_n(brake_n), .raw(raw), .pins(pins));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task automatic apb(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      n_mismatch++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic set_ctrl();
    apb(1'b1, GID_OFS_CTRL, {25'h0, en_v, rc_v, mode_v});
  endtask : set_ctrl

  // commutation index after the direction input
  function automatic logic [2:0] exp_index();
    return (dir && code != GID_CODE_STOP && code != GID_CODE_ALIGN) ? ~code : code;
  endfunction : exp_index

  function automatic gid_gate_s exp_gates();
    gid_gate_s g;
    logic [2:0] c, src, snk;
    g = '0;
    c = exp_index();
    case (c)
      3'h7: {src, snk} = 6'b001_110;
      3'h6: {src, snk} = 6'b010_100;
      3'h4: {src, snk} = 6'b001_100;
      3'h5: {src, snk} = 6'b001_010;
      3'h1: {src, snk} = 6'b100_010;
      3'h3: {src, snk} = 6'b100_001;
      3'h2: {src, snk} = 6'b010_001;
      default: {src, snk} = 6'h00;
    endcase
    case (mode_v)
      GID_MODE_SIX: g = '{high: raw.high & ~raw.low, low: raw.low & ~raw.high};
      GID_MODE_THREE_PIN: g = '{high: raw.low & raw.high, low: raw.low & ~raw.high};
      GID_MODE_THREE_REG: g = '{high: raw.high, low: ~raw.high};
      GID_MODE_SINGLE: g = !brake_n ? '{high: 3'h0, low: 3'h7} :
        '{high: pwm ? src : 3'h0, low: snk | ((rc_v || pwm) ? 3'h0 : src)};
      GID_MODE_SWREG: g = '{high: cmd_v[5:3] & ~cmd_v[2:0], low: cmd_v[2:0] & ~cmd_v[5:3]};
      default: g = '0;
    endcase
    g.high = g.high & en_v;
    g.low = g.low & en_v;
    return g;
  endfunction : exp_gates

  task automatic look(input string what);
    repeat (8) @(posedge pclk);
    check(what, {26'h0, gate_out}, {26'h0, exp_gates()});
  endtask : look

  task automatic t_reset();
    check("gates in reset", {26'h0, gate_out}, 32'h0);
    apb(1'b0, GID_OFS_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h70);
    apb(1'b0, 4'hC, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, GID_OFS_STATUS, 32'hFFFFFFFF);
    check("status write err", {31'h0, err}, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_three_reg();
    mode_v = GID_MODE_THREE_REG;
    for (int e = 0; e < 8; e++) begin
      en_v = 3'(e);
      set_ctrl();
      for (int h = 0; h < 8; h++) begin
        raw <= '{high: 3'(h), low: 3'(h) ^ 3'h5};
        look("three input reg enable");
      end
    end
    $display("test three_reg done");
  endtask : t_three_reg

  task automatic t_single();
    gid_gate_s g;
    single <= 1'b1;
    mode_v = GID_MODE_SINGLE;
    for (int k = 0; k < 64; k++) begin
      rc_v = k[5];
      en_v = (k[5:4] == 2'h3) ? 3'h6 : 3'h7;
      if (k[3:0] == 4'h0) begin
        set_ctrl();
      end
      dir <= k[4];
      code <= k[3:1];
      pwm <= k[0];
      look("single pwm step");
      apb(1'b0, GID_OFS_STATUS, 32'h0);
      g = exp_gates();
      check("status", rd, {21'h0, exp_index(), 1'b0, g.low, 1'b0, g.high});
      check("pready", {31'h0, pready}, 32'h1);
    end
    brake_n <= 1'b0;
    en_v = 3'h5;
    set_ctrl();
    for (int c = 0; c < 8; c++) begin
      code <= 3'(c);
      pwm <= 1'b1;
      look("brake");
    end
    brake_n <= 1'b1;
    single <= 1'b0;
    $display("test single done");
  endtask : t_single

  task automatic t_pin_modes();
    for (int m = 0; m < 2; m++) begin
      mode_v = m ? GID_MODE_THREE_PIN : GID_MODE_SIX;
      en_v = m ? 3'h5 : 3'h7;
      set_ctrl();
      for (int p = 0; p < 64; p++) begin
        raw <= gid_pins_s'(6'(p));
        look("pin modes");
      end
    end
    $display("test pin_modes done");
  endtask : t_pin_modes

  task automatic t_swreg();
    mode_v = GID_MODE_SWREG;
    for (int k = 0; k < 64; k++) begin
      en_v = k[0] ? 3'h7 : 3'h3;
      set_ctrl();
      cmd_v = 6'(k);
      apb(1'b1, GID_OFS_GATE_CMD, {25'h0, cmd_v[5:3], 1'b0, cmd_v[2:0]});
      look("software gates");
      apb(1'b0, GID_OFS_GATE_CMD, 32'h0);
      check("cmd readback", rd, {25'h0, cmd_v[5:3], 1'b0, cmd_v[2:0]});
    end
    $display("test swreg done");
  endtask : t_swreg

  task automatic t_bad_mode();
    for (int m = 5; m < 8; m++) begin
      mode_v = 3'(m);
      set_ctrl();
      look("undefined mode");
    end
    mode_v = GID_MODE_SWREG;
    cmd_v = 6'h08;
    set_ctrl();
    apb(1'b1, GID_OFS_GATE_CMD, 32'h10);
    look("before reset");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check("gates mid reset", {26'h0, gate_out}, 32'h0);
    presetn <= 1'b1;
    $display("test bad_mode done");
  endtask : t_bad_mode

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 4'h0;
    pwdata = 32'h0;
    raw = '0;
    single = 1'b0;
    pwm = 1'b0;
    code = 3'h0;
    dir = 1'b0;
    brake_n = 1'b1;
    rc_v = 1'b0;
    cmd_v = 6'h00;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (2) @(posedge pclk);
    check("gates held in reset", {26'h0, gate_out}, 32'h0);
    presetn <= 1'b1;
    t_reset();
    t_reset();
    t_three_reg();
    t_single();
    t_pin_modes();
    t_swreg();
    t_bad_mode();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
